// *** core/air_defines.svh ***
// air_defines.svh: register offsets, reset values, field positions and timing counts
// assumes inclusion by bare name from design files
`ifndef AIR_DEFINES_SVH
`define AIR_DEFINES_SVH
`define AIR_OFS_SLEEP_COUNT   8'h29
`define AIR_OFS_IRQ_CONTROL   8'h2C
`define AIR_OFS_IRQ_ENABLE    8'h2D
`define AIR_OFS_IRQ_ROUTE     8'h2E
`define AIR_OFS_MAIN_CONTROL  8'h2A
`define AIR_OFS_POWER_CONTROL 8'h2B
`define AIR_OFS_SYSTEM_MODE   8'h0B
`define AIR_RST_SLEEP_COUNT   8'h00
`define AIR_RST_IRQ_CONTROL   8'h00
`define AIR_RST_IRQ_ENABLE    8'h00
`define AIR_RST_IRQ_ROUTE     8'h00
`define AIR_RST_MAIN_CONTROL  8'h00
`define AIR_RST_POWER_CONTROL 8'h00
// event bit positions, shared by enable, route and source vectors
`define AIR_BIT_SLEEP   7
`define AIR_BIT_FIFO    6
`define AIR_BIT_TRANS   5
`define AIR_BIT_ORIENT  4
`define AIR_BIT_TAP     3
`define AIR_BIT_MOTION  2
`define AIR_BIT_MAGN    1
`define AIR_BIT_DRDY    0
// irq control register fields
`define AIR_CTL_FIFO_GATE 7
`define AIR_CTL_IPOL      1
`define AIR_CTL_DRIVE     0
// irq control register: wake enables per wake-capable source
`define AIR_CTL_WAKE_TRANS  6
`define AIR_CTL_WAKE_ORIENT 5
`define AIR_CTL_WAKE_TAP    4
`define AIR_CTL_WAKE_MOTION 3
`define AIR_CTL_WAKE_MAGN   2
// system mode word fields
`define AIR_SYS_FGERR  7
`define AIR_SYS_SLEEP  1
`define AIR_SYS_ACTIVE 0
// power control register: auto-sleep enable
`define AIR_PWR_SLPE      2
// main control register: sleep rate at 7:6, active rate at 5:3
`define AIR_MAIN_SLOW_RATE 2'h3
`define AIR_RATE_HI        5
`define AIR_RATE_LO        3
`define AIR_SLOW_ACTIVE    3'h7
// inactivity step times
`define AIR_STEP_MS        320
`define AIR_STEP_SLOW_MS   640
`define AIR_CLK_HZ         25000000
`endif

// *** core/air_irq_router.sv ***
// air_irq_router.sv: interrupt enable, routing, pin drive and auto-sleep control
// assumes event flags and register port on clk; pins resolved outside from enables
// Functional notes
// - enable bit gates each event source
// - route bit 1 first pin, 0 second
// - sources on one pin are ORed
// - auto-sleep after programmed inactivity time
// - step 320 ms, 640 ms at slowest rate
// - all but sleep/wake and data-ready restart inactivity timer
// - motion-type sources wake; FIFO, sleep/wake never
// - only enabled sources affect sleep logic
// - bypassed flags masked in sleep, restored except data-ready
// - restart source clears counter, cancels sleep
// - no restart source means enter sleep
// - wake needs its wake enable bit
// - every mode change raises sleep/wake event
// - fifo gate keeps contents, flags error, blocks samples
// - polarity bit: 0 active low, 1 high
// - drive bit: 0 push-pull, 1 open-drain
`timescale 1ns/1ps
`default_nettype none
`include "air_defines.svh"
module air_irq_router
  import air_pkg::*;
#(
  parameter int unsigned STEP_CYC      = `AIR_CLK_HZ / 1000 * `AIR_STEP_MS,
  parameter int unsigned STEP_SLOW_CYC = `AIR_CLK_HZ / 1000 * `AIR_STEP_SLOW_MS
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] event_flags,
  input  wire logic       sleep_event_clr,
  input  wire logic       fifo_empty,
  input  wire logic       sample_strobe,
  output logic      [7:0] source_flags,
  output logic            sample_block,
  output logic            sleep_mode,
  output logic            irq_pin_first_out,
  output logic            irq_pin_first_oe,
  output logic            irq_pin_second_out,
  output logic            irq_pin_second_oe
);
  logic [7:0]   sleep_count_ff;
  logic [7:0]   irq_control_ff;
  logic [7:0]   irq_enable_ff;
  logic [7:0]   irq_route_ff;
  logic [7:0]   main_control_ff;
  logic [7:0]   power_control_ff;
  air_mode_type mode_ff;
  air_mode_type nxt_mode;
  logic [7:0]   inact_ff;
  logic         sleep_flag_ff;
  logic         gate_ff;
  logic         fgerr_ff;
  logic [7:0]   rdata_ff;
  logic [7:0]   wake_mask;
  logic [7:0]   live_flags;
  logic [7:0]   enabled;
  logic [7:0]   restart_mask;
  logic         restart;
  logic         wake_hit;
  logic         step_pulse;
  logic         mode_change;
  logic         first_act;
  logic         second_act;
  logic         drdy_off_ff;
  logic         step_restart;
  logic         slow_rate;
  logic [7:0]   sysmode_word;
  logic [1:0]   pin_act;
  logic [1:0]   pin_level;
  logic [1:0]   pin_out;
  logic [1:0]   pin_oe;

  // wake enable bits of the irq control register, per event position
  always_comb
  begin
    wake_mask                 = 8'h00;
    wake_mask[`AIR_BIT_TRANS]  = irq_control_ff[`AIR_CTL_WAKE_TRANS];
    wake_mask[`AIR_BIT_ORIENT] = irq_control_ff[`AIR_CTL_WAKE_ORIENT];
    wake_mask[`AIR_BIT_TAP]    = irq_control_ff[`AIR_CTL_WAKE_TAP];
    wake_mask[`AIR_BIT_MOTION] = irq_control_ff[`AIR_CTL_WAKE_MOTION];
    wake_mask[`AIR_BIT_MAGN]   = irq_control_ff[`AIR_CTL_WAKE_MAGN];
  end

  // flags bypassed in sleep are held off; data-ready stays off after sleep
  always_comb
  begin
    live_flags = event_flags;
    live_flags[`AIR_BIT_SLEEP] = sleep_flag_ff;
    if (drdy_off_ff)
      live_flags[`AIR_BIT_DRDY] = 1'b0;
    if (mode_ff == AIR_SLEEP)
      live_flags = live_flags & (wake_mask | 8'h80);
  end

  assign enabled      = live_flags & irq_enable_ff;
  assign restart_mask = 8'h7E;
  assign restart      = |(enabled & restart_mask);
  assign wake_hit     = |(enabled & wake_mask);

  // register writes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sleep_count_ff   <= `AIR_RST_SLEEP_COUNT;
      irq_control_ff   <= `AIR_RST_IRQ_CONTROL;
      irq_enable_ff    <= `AIR_RST_IRQ_ENABLE;
      irq_route_ff     <= `AIR_RST_IRQ_ROUTE;
      main_control_ff  <= `AIR_RST_MAIN_CONTROL;
      power_control_ff <= `AIR_RST_POWER_CONTROL;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `AIR_OFS_SLEEP_COUNT)
        sleep_count_ff <= reg_wdata;
      else if (reg_addr == `AIR_OFS_IRQ_CONTROL)
        irq_control_ff <= reg_wdata;
      else if (reg_addr == `AIR_OFS_IRQ_ENABLE)
        irq_enable_ff <= reg_wdata;
      else if (reg_addr == `AIR_OFS_IRQ_ROUTE)
        irq_route_ff <= reg_wdata;
      else if (reg_addr == `AIR_OFS_MAIN_CONTROL)
        main_control_ff <= reg_wdata;
      else if (reg_addr == `AIR_OFS_POWER_CONTROL)
        power_control_ff <= reg_wdata;
    end
  end

  // system mode word: gate error, sleep state, always-active bit
  always_comb
  begin
    sysmode_word                  = 8'h00;
    sysmode_word[`AIR_SYS_FGERR]  = fgerr_ff;
    sysmode_word[`AIR_SYS_SLEEP]  = (mode_ff == AIR_SLEEP);
    sysmode_word[`AIR_SYS_ACTIVE] = 1'b1;
  end

  // register reads, data registered
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata_ff <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `AIR_OFS_SLEEP_COUNT)
        rdata_ff <= sleep_count_ff;
      else if (reg_addr == `AIR_OFS_IRQ_CONTROL)
        rdata_ff <= irq_control_ff;
      else if (reg_addr == `AIR_OFS_IRQ_ENABLE)
        rdata_ff <= irq_enable_ff;
      else if (reg_addr == `AIR_OFS_IRQ_ROUTE)
        rdata_ff <= irq_route_ff;
      else if (reg_addr == `AIR_OFS_MAIN_CONTROL)
        rdata_ff <= main_control_ff;
      else if (reg_addr == `AIR_OFS_POWER_CONTROL)
        rdata_ff <= power_control_ff;
      else if (reg_addr == `AIR_OFS_SYSTEM_MODE)
        rdata_ff <= sysmode_word;
      else
        rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

  assign step_restart = restart || (mode_ff != AIR_WAKE);
  assign slow_rate = main_control_ff[`AIR_RATE_HI:`AIR_RATE_LO] == `AIR_SLOW_ACTIVE;

  air_step_timer #(
    .STEP_CYC      (STEP_CYC),
    .STEP_SLOW_CYC (STEP_SLOW_CYC)
  ) u_step (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .restart    (step_restart),
    .slow_step  (slow_rate),
    .step_pulse (step_pulse)
  );

  // mode decision
  always_comb
  begin
    nxt_mode = mode_ff;
    case (mode_ff)
      AIR_WAKE:
        if (power_control_ff[`AIR_PWR_SLPE] && !restart &&
            (inact_ff >= sleep_count_ff))
          nxt_mode = AIR_SLEEP;
      AIR_SLEEP:
        if (!power_control_ff[`AIR_PWR_SLPE] || wake_hit)
          nxt_mode = AIR_WAKE;
      default:
        nxt_mode = AIR_WAKE;
    endcase
  end

  assign mode_change = (nxt_mode != mode_ff);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mode_ff <= AIR_WAKE;
    else
      mode_ff <= nxt_mode;
  end

  // inactivity steps since last restart
  always_ff @(posedge clk)
  begin
    if (sys_rst || restart || mode_ff != AIR_WAKE)
      inact_ff <= 8'h00;
    else if (step_pulse && inact_ff != 8'hFF)
      inact_ff <= inact_ff + 8'h01;
  end

  // sleep/wake event flag, set wins over clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sleep_flag_ff <= 1'b0;
    else if (mode_change)
      sleep_flag_ff <= 1'b1;
    else if (sleep_event_clr)
      sleep_flag_ff <= 1'b0;
  end

  // data-ready stays masked after a wake until the enable register is rewritten
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      drdy_off_ff <= 1'b0;
    else if (mode_ff == AIR_SLEEP)
      drdy_off_ff <= 1'b1;
    else if (reg_wr && reg_addr == `AIR_OFS_IRQ_ENABLE)
      drdy_off_ff <= 1'b0;
  end

  // fifo gate: block samples after a mode change until emptied
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      gate_ff <= 1'b0;
    else if (mode_change && irq_control_ff[`AIR_CTL_FIFO_GATE])
      gate_ff <= 1'b1;
    else if (fifo_empty)
      gate_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fgerr_ff <= 1'b0;
    else if (gate_ff && sample_strobe && !fifo_empty)
      fgerr_ff <= 1'b1;
    else if (fifo_empty)
      fgerr_ff <= 1'b0;
  end

  assign sample_block = gate_ff;
  assign sleep_mode   = (mode_ff == AIR_SLEEP);
  assign source_flags = enabled;

  assign first_act  = |(enabled & irq_route_ff);
  assign second_act = |(enabled & ~irq_route_ff);

  assign pin_act = {first_act, second_act};

  // per pin: polarity first, then push-pull or open-drain drive
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    assign pin_level[p] = pin_act[p] ~^ irq_control_ff[`AIR_CTL_IPOL];
    assign pin_out[p]   = irq_control_ff[`AIR_CTL_DRIVE] ? 1'b0 : pin_level[p];
    assign pin_oe[p]    = irq_control_ff[`AIR_CTL_DRIVE] ? !pin_level[p] : 1'b1;
  end

  assign irq_pin_first_out  = pin_out[1];
  assign irq_pin_first_oe   = pin_oe[1];
  assign irq_pin_second_out = pin_out[0];
  assign irq_pin_second_oe  = pin_oe[0];
endmodule : air_irq_router
`default_nettype wire

// *** core/air_pkg.sv ***
// air_pkg.sv: types of the interrupt router and auto-sleep block
// assumes nothing beyond the defines header
package air_pkg;
  typedef enum logic [1:0] {
    AIR_WAKE  = 2'b01,
    AIR_SLEEP = 2'b10
  } air_mode_type;
endpackage : air_pkg

// *** core/air_step_timer.sv ***
// air_step_timer.sv: emits one-cycle pulse per inactivity step
// assumes clk at AIR_CLK_HZ, step length chosen by caller
`timescale 1ns/1ps
`default_nettype none
`include "air_defines.svh"
module air_step_timer
  import air_pkg::*;
#(
  parameter int unsigned STEP_CYC      = `AIR_CLK_HZ / 1000 * `AIR_STEP_MS,
  parameter int unsigned STEP_SLOW_CYC = `AIR_CLK_HZ / 1000 * `AIR_STEP_SLOW_MS
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic restart,
  input  wire logic slow_step,
  output logic      step_pulse
);
  logic [31:0] cnt_ff;
  logic [31:0] limit;

  assign limit = slow_step ? STEP_SLOW_CYC : STEP_CYC;

  always_ff @(posedge clk)
  begin
    if (sys_rst || restart)
      cnt_ff <= 32'h0;
    else if (cnt_ff >= limit - 32'h1)
      cnt_ff <= 32'h0;
    else
      cnt_ff <= cnt_ff + 32'h1;
  end

  assign step_pulse = !restart && (cnt_ff >= limit - 32'h1);
endmodule : air_step_timer
`default_nettype wire

// *** test/accel_irq_router_autosleep_tb.sv ***
// accel_irq_router_autosleep_tb.sv: self-checking bench of the interrupt router
// assumes short inactivity steps of 10 and 20 cycles
`timescale 1ns/1ps
`default_nettype none
module accel_irq_router_autosleep_tb
  import air_pkg::*;
;
  logic       clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, event_flags = 8'h00;
  logic       sleep_event_clr = 1'h0, fifo_empty = 1'h0, sample_strobe = 1'h0;
  logic [7:0] reg_rdata, source_flags;
  logic       sample_block, sleep_mode, irq_pin_first_out, irq_pin_first_oe;
  logic       irq_pin_second_out, irq_pin_second_oe, line_first, line_second;
  int         fail_count = 0;
  int         n_compared = 0;
  wire  logic [7:0] pins = {6'h00, line_first, line_second};
  always #20 clk = ~clk;
  air_irq_router #(.STEP_CYC(10), .STEP_SLOW_CYC(20)) air_irq_router_i (
    .clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .event_flags,
    .sleep_event_clr, .fifo_empty, .sample_strobe, .source_flags, .sample_block, .sleep_mode,
    .irq_pin_first_out, .irq_pin_first_oe, .irq_pin_second_out, .irq_pin_second_oe);
  air_host_model air_host_model_i (.irq_pin_first_out, .irq_pin_first_oe,
    .irq_pin_second_out, .irq_pin_second_oe, .line_first, .line_second);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1 reg_rd = 1'h1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'h0;
  endtask : rd
  task automatic ev(input logic [7:0] f);
    @(posedge clk);
    #1 event_flags = f;
    #1;
  endtask : ev
  task automatic t_regs;
    logic [7:0] a[6] = '{8'h29, 8'h2E, 8'h2D, 8'h2C, 8'h2A, 8'h2B};
    foreach (a[i])
    begin
      rd(a[i]);
      chk(reg_rdata, 8'h00);
      wr(a[i], 8'h5A);
      rd(a[i]);
      chk(reg_rdata, 8'h5A);
      wr(a[i], 8'h00);
    end
    wr(8'h50, 8'hFF);
    rd(8'h50);
    chk(reg_rdata, 8'h00);
    rd(8'h0B);
    chk(reg_rdata, 8'h01);
  endtask : t_regs
  task automatic t_route;
    wr(8'h2D, 8'h7F);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h2E, 8'h01 << i);
      ev(8'h01 << i);
      chk(pins, 8'h01);
      wr(8'h2E, 8'h00);
      chk(pins, 8'h02);
    end
    wr(8'h2D, 8'h00);
    chk(pins, 8'h03);
  endtask : t_route
  task automatic t_or_pol;
    wr(8'h2D, 8'h7F);
    wr(8'h2E, 8'h7F);
    ev(8'h0C);
    chk(source_flags, 8'h0C);
    ev(8'h08);
    chk(pins, 8'h01);
    ev(8'h00);
    chk(pins, 8'h03);
    ev(8'h04);
    wr(8'h2C, 8'h02);
    chk(pins, 8'h02);
    wr(8'h2C, 8'h01);
    chk(pins, 8'h01);
    chk({7'h00, irq_pin_second_oe}, 8'h00);
    wr(8'h2C, 8'h00);
    ev(8'h00);
  endtask : t_or_pol
  task automatic wait_sleep(input int lo, input int hi);
    int n = 0;
    ev(8'h08);
    while (sleep_mode !== 1'h1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
    chk(pins, 8'h01);
    chk(source_flags, 8'h80);
  endtask : wait_sleep
  task automatic t_sleep;
    wr(8'h29, 8'h02);
    wr(8'h2D, 8'hE5);
    wr(8'h2E, 8'h80);
    wr(8'h2C, 8'hC0);
    ev(8'h04);
    wr(8'h2B, 8'h04);
    repeat (40) @(posedge clk);
    #1 chk({7'h00, sleep_mode}, 8'h00);
    wait_sleep(19, 32);
    chk({7'h00, sample_block}, 8'h01);
    sample_strobe = 1'h1;
    @(posedge clk);
    #1 sample_strobe = 1'h0;
    rd(8'h0B);
    chk(reg_rdata, 8'h83);
    fifo_empty = 1'h1;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, sample_block}, 8'h00);
    fifo_empty = 1'h0;
    ev(8'h40);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, sleep_mode}, 8'h01);
    sleep_event_clr = 1'h1;
    @(posedge clk);
    #1 sleep_event_clr = 1'h0;
    chk(pins, 8'h03);
    ev(8'h61);
    @(posedge clk);
    #1 chk({7'h00, sleep_mode}, 8'h00);
    chk(pins, 8'h00);
    chk(source_flags, 8'hE0);
    wr(8'h2A, 8'h38);
    wait_sleep(39, 64);
    wr(8'h2B, 8'h00);
    @(posedge clk);
    #1 chk({7'h00, sleep_mode}, 8'h00);
  endtask : t_sleep
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'h0;
    t_regs();
    t_route();
    t_or_pol();
    t_sleep();
    conclude();
  end
  initial
  begin
    #400000;
    fail_count++;
    conclude();
  end
endmodule : accel_irq_router_autosleep_tb
`default_nettype wire

// *** test/air_host_model.sv ***
// air_host_model.sv: host side of the interrupt lines
// assumes an external pull-up on each line
`timescale 1ns/1ps
`default_nettype none
module air_host_model (
  input  wire logic irq_pin_first_out,
  input  wire logic irq_pin_first_oe,
  input  wire logic irq_pin_second_out,
  input  wire logic irq_pin_second_oe,
  output logic      line_first,
  output logic      line_second
);
  assign line_first  = irq_pin_first_oe ? irq_pin_first_out : 1'h1;
  assign line_second = irq_pin_second_oe ? irq_pin_second_out : 1'h1;
endmodule : air_host_model
`default_nettype wire

// *** test/air_irq_router_asserts.sv ***
// air_irq_router_asserts.sv: port checker for the interrupt router
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module air_irq_router_asserts
  import air_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] event_flags,
  input wire logic [7:0] source_flags,
  input wire logic       sample_block,
  input wire logic       sleep_mode,
  input wire logic       irq_pin_first_out,
  input wire logic       irq_pin_first_oe,
  input wire logic       irq_pin_second_out,
  input wire logic       irq_pin_second_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_enable_gate: assert property ((source_flags[6:0] & ~event_flags[6:0]) == 7'h00)
    else $error("source flag without event flag");
  a_idle_pins: assert property (source_flags == 8'h00 |->
    irq_pin_first_oe == irq_pin_second_oe &&
    (!irq_pin_first_oe || irq_pin_first_out == irq_pin_second_out))
    else $error("pins differ while no source is set");
  a_reset_state: assert property (disable iff (1'h0) sys_rst |=>
    irq_pin_first_out && irq_pin_first_oe && irq_pin_second_out && irq_pin_second_oe &&
    !sleep_mode && reg_rdata == 8'h00)
    else $error("wrong state after reset");
  a_read_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_sleep_mask: assert property (sleep_mode |-> !source_flags[6] && !source_flags[0])
    else $error("bypassed flag passed in sleep");
  a_restart_blocks: assert property (!sleep_mode && (|source_flags[6:1]) |=> !sleep_mode)
    else $error("sleep entered with restart source");
  a_wake_source: assert property (sleep_mode && (|source_flags[5:1]) |=> !sleep_mode)
    else $error("no wake on enabled wake source");
  a_gate_on_change: assert property ($rose(sample_block) |->
    $changed(sleep_mode) || $past(sleep_mode, 2) != $past(sleep_mode))
    else $error("sample block without mode change");
endmodule : air_irq_router_asserts
bind air_irq_router air_irq_router_asserts air_irq_router_asserts_i (
  .clk, .sys_rst, .reg_rd, .reg_rdata, .event_flags, .source_flags, .sample_block,
  .sleep_mode, .irq_pin_first_out, .irq_pin_first_oe, .irq_pin_second_out, .irq_pin_second_oe
);
`default_nettype wire
